// [abr_bias_regs.sv]
// Purpose: analogue reference, bias, input mixer and line-output anti-pop control registers
// Assumes: register port driven by the control interface logic on sys_clk
// Notes:   all field and derived control outputs come from flip-flops
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - two-bit mid-rail divider select, reset off
// - mid-rail slew fast bit zero, reset one
// - bias source select bit six, reset start-up
// - standby bias level bit five, reset quarter
// - standby enable picks standby over master level
// - master bias level bits three:two, reset 1x
// - normal bias generator enable bit one
// - start-up bias generator enable bit zero
// - mixer: dac, input enables, input attenuation
// - line-output discharge bit two, about 5k
// - clamp resistance 20k or 500 ohm
// - clamp only while line output is disabled
// - mid-rail soft start bit three, reset zero
// - buffered mid-rail enable bit five, reset zero
module abr_bias_regs
    import abr_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // register port
    input  wire logic        reg_wr_en,
    input  wire logic        reg_rd_en,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    output logic             reg_rd_valid,
    output logic             reg_addr_hit,
    // state of the line output, from the power management bank
    input  wire logic        line_output_enable,
    // reference controls
    output logic [1:0]       midrail_divider_select,
    output logic [3:0]       midrail_divider_onehot,
    output logic             midrail_slew_fast,
    output logic             midrail_soft_start,
    output logic             midrail_buffer_enable,
    // bias controls
    output logic             bias_source_select,
    output logic             standby_bias_level,
    output logic             standby_bias_enable,
    output logic [1:0]       master_bias_level,
    output logic             normal_bias_enable,
    output logic             startup_bias_enable,
    output logic [2:0]       bias_current_quarters,
    output logic             selected_bias_running,
    // mixer controls
    output logic             dac_path_enable,
    output logic             input_one_enable,
    output logic             input_one_attenuate,
    output logic             input_two_enable,
    output logic             input_two_attenuate,
    // line-output anti-pop controls
    output logic             line_output_discharge,
    output logic             line_clamp_request,
    output logic             line_clamp_resistance,
    output logic             line_clamp_active,
    output logic             line_clamp_low_ohm,
    output logic             line_clamp_unbuffered
);

    localparam abr_word_t MASKS  [ABR_NUM_REGS] = '{ABR_MIDRAIL_MASK, ABR_BIAS_MASK,
                                                     ABR_MIXER_MASK, ABR_ANTIPOP_MASK};
    localparam abr_word_t RESETS [ABR_NUM_REGS] = '{ABR_MIDRAIL_RESET, ABR_BIAS_RESET,
                                                     ABR_MIXER_RESET, ABR_ANTIPOP_RESET};

    abr_word_t        regs [ABR_NUM_REGS];
    logic [3:0]       sel;
    logic [15:0]      rdata_nxt;
    logic [2:0]       quarters_nxt;
    logic             clamp_nxt;

    // one-hot slot decode, shared by write and read paths
    function automatic logic [3:0] abr_decode(input logic [6:0] addr);
        logic [3:0] hit;
        hit = 4'h0;
        case (addr)
            ABR_MIDRAIL_ADDR: hit[ABR_SLOT_MIDRAIL] = 1'b1;
            ABR_BIAS_ADDR:    hit[ABR_SLOT_BIAS]    = 1'b1;
            ABR_MIXER_ADDR:   hit[ABR_SLOT_MIXER]   = 1'b1;
            ABR_ANTIPOP_ADDR: hit[ABR_SLOT_ANTIPOP] = 1'b1;
            default:          hit = 4'h0;
        endcase
        return hit;
    endfunction

    // master bias code to quarters of the normal bias
    function automatic logic [2:0] abr_master_quarters(input logic [1:0] code);
        logic [2:0] q;
        case (code)
            2'h0:    q = ABR_BIAS_Q_HALF;
            2'h1:    q = ABR_BIAS_Q_3QUARTER;
            2'h2:    q = ABR_BIAS_Q_FULL;
            default: q = ABR_BIAS_Q_1P5;
        endcase
        return q;
    endfunction

    assign sel          = abr_decode(reg_addr);
    assign reg_addr_hit = |sel;

    // masked storage; writes to unmapped indices or unlisted bits are dropped
    genvar gi;
    generate
        for (gi = 0; gi < ABR_NUM_REGS; gi++)
        begin : g_reg
            abr_field_reg #(
                .MASK  (MASKS[gi]),
                .RESET (RESETS[gi])
            ) u_reg (
                .sys_clk (sys_clk),
                .rst     (rst),
                .wr_en   (reg_wr_en & sel[gi]),
                .wdata   (reg_wdata),
                .q       (regs[gi])
            );
        end
    endgenerate

    // read mux; unmapped indices read as zero
    always_comb
    begin
        rdata_nxt = 16'h0000;
        for (int i = 0; i < ABR_NUM_REGS; i++)
        begin
            if (sel[i])
            begin
                rdata_nxt = regs[i];
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            reg_rdata    <= 16'h0000;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en)
            begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

    // reference fields
    assign midrail_divider_select = regs[ABR_SLOT_MIDRAIL][ABR_MID_SEL_LSB +: 2];
    assign midrail_slew_fast      = regs[ABR_SLOT_MIDRAIL][ABR_MID_SLEW_BIT];
    assign midrail_soft_start     = regs[ABR_SLOT_MIDRAIL][ABR_MID_SOFT_BIT];
    assign midrail_buffer_enable  = regs[ABR_SLOT_MIDRAIL][ABR_MID_BUF_EN_BIT];

    // divider mode as one-hot: off, normal, standby, fast start-up
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            midrail_divider_onehot <= 4'h1;
        end
        else
        begin
            case (midrail_divider_select)
                ABR_MID_OFF:     midrail_divider_onehot <= 4'h1;
                ABR_MID_NORMAL:  midrail_divider_onehot <= 4'h2;
                ABR_MID_STANDBY: midrail_divider_onehot <= 4'h4;
                ABR_MID_FAST:    midrail_divider_onehot <= 4'h8;
                default:         midrail_divider_onehot <= 4'h1;
            endcase
        end
    end

    // bias fields
    assign bias_source_select  = regs[ABR_SLOT_BIAS][ABR_BIAS_SOURCE_SELECT_BIT];
    assign standby_bias_level  = regs[ABR_SLOT_BIAS][ABR_BIAS_STBY_LVL_BIT];
    assign standby_bias_enable = regs[ABR_SLOT_BIAS][ABR_BIAS_STBY_EN_BIT];
    assign master_bias_level   = regs[ABR_SLOT_BIAS][ABR_MASTER_BIAS_LEVEL_LSB +: 2];
    assign normal_bias_enable  = regs[ABR_SLOT_BIAS][ABR_BIAS_NORM_EN_BIT];
    assign startup_bias_enable = regs[ABR_SLOT_BIAS][ABR_BIAS_START_EN_BIT];

    // effective bias current: standby level overrides master level when enabled
    always_comb
    begin
        if (standby_bias_enable)
        begin
            quarters_nxt = standby_bias_level ? ABR_BIAS_Q_QUARTER : ABR_BIAS_Q_HALF;
        end
        else
        begin
            quarters_nxt = abr_master_quarters(master_bias_level);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bias_current_quarters <= ABR_BIAS_Q_QUARTER;
            selected_bias_running <= 1'b0;
        end
        else
        begin
            bias_current_quarters <= quarters_nxt;
            // the chosen source has its generator switched on
            selected_bias_running <= bias_source_select ? startup_bias_enable
                                                        : normal_bias_enable;
        end
    end

    // mixer fields
    assign dac_path_enable     = regs[ABR_SLOT_MIXER][ABR_MIX_DAC_BIT];
    assign input_two_attenuate = regs[ABR_SLOT_MIXER][ABR_MIX_IN2_ATT_BIT];
    assign input_two_enable    = regs[ABR_SLOT_MIXER][ABR_MIX_IN2_EN_BIT];
    assign input_one_attenuate = regs[ABR_SLOT_MIXER][ABR_MIX_IN1_ATT_BIT];
    assign input_one_enable    = regs[ABR_SLOT_MIXER][ABR_MIX_IN1_EN_BIT];

    // anti-pop fields
    assign line_output_discharge = regs[ABR_SLOT_ANTIPOP][ABR_AP_DISCH_BIT];
    assign line_clamp_resistance = regs[ABR_SLOT_ANTIPOP][ABR_AP_CLAMP_RES_BIT];
    assign line_clamp_request    = regs[ABR_SLOT_ANTIPOP][ABR_AP_CLAMP_BIT];

    // clamp applies only with the line output off
    assign clamp_nxt = line_clamp_request & ~line_output_enable;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            line_clamp_active     <= 1'b0;
            line_clamp_low_ohm    <= 1'b0;
            line_clamp_unbuffered <= 1'b0;
        end
        else
        begin
            line_clamp_active     <= clamp_nxt;
            line_clamp_low_ohm    <= clamp_nxt & line_clamp_resistance;
            // clamp asked for without the buffered mid-rail behind it
            line_clamp_unbuffered <= clamp_nxt & ~midrail_buffer_enable;
        end
    end

endmodule
`default_nettype wire

// [abr_pkg.sv]
// Purpose: shared constants for the analogue reference and bias control register bank
// Assumes: 7-bit register index, 16-bit register data
// Notes:   masks mark the bits that hold a field; all other bits read as zero
`default_nettype none
package abr_pkg;

    localparam int ABR_ADDR_W = 7;
    localparam int ABR_DATA_W = 16;
    localparam int ABR_NUM_REGS = 4;

    // register indices
    localparam logic [6:0] ABR_MIDRAIL_ADDR = 7'h04;
    localparam logic [6:0] ABR_BIAS_ADDR    = 7'h05;
    localparam logic [6:0] ABR_MIXER_ADDR   = 7'h07;
    localparam logic [6:0] ABR_ANTIPOP_ADDR = 7'h08;

    // slot numbers in the register array
    localparam int ABR_SLOT_MIDRAIL = 0;
    localparam int ABR_SLOT_BIAS    = 1;
    localparam int ABR_SLOT_MIXER   = 2;
    localparam int ABR_SLOT_ANTIPOP = 3;

    // writable bit masks
    localparam logic [15:0] ABR_MIDRAIL_MASK = 16'h002f;
    localparam logic [15:0] ABR_BIAS_MASK    = 16'h007f;
    localparam logic [15:0] ABR_MIXER_MASK   = 16'h001f;
    localparam logic [15:0] ABR_ANTIPOP_MASK = 16'h0007;

    // reset values
    localparam logic [15:0] ABR_MIDRAIL_RESET = 16'h0001;
    localparam logic [15:0] ABR_BIAS_RESET    = 16'h0068;
    localparam logic [15:0] ABR_MIXER_RESET   = 16'h0000;
    localparam logic [15:0] ABR_ANTIPOP_RESET = 16'h0000;

    // reference register fields
    localparam int ABR_MID_BUF_EN_BIT   = 5;
    localparam int ABR_MID_SOFT_BIT     = 3;
    localparam int ABR_MID_SEL_LSB      = 1;
    localparam int ABR_MID_SLEW_BIT     = 0;

    // bias register fields
    localparam int ABR_BIAS_SOURCE_SELECT_BIT     = 6;
    localparam int ABR_BIAS_STBY_LVL_BIT = 5;
    localparam int ABR_BIAS_STBY_EN_BIT = 4;
    localparam int ABR_MASTER_BIAS_LEVEL_LSB     = 2;
    localparam int ABR_BIAS_NORM_EN_BIT = 1;
    localparam int ABR_BIAS_START_EN_BIT = 0;

    // mixer register fields
    localparam int ABR_MIX_DAC_BIT      = 4;
    localparam int ABR_MIX_IN2_ATT_BIT  = 3;
    localparam int ABR_MIX_IN2_EN_BIT   = 2;
    localparam int ABR_MIX_IN1_ATT_BIT  = 1;
    localparam int ABR_MIX_IN1_EN_BIT   = 0;

    // anti-pop register fields
    localparam int ABR_AP_DISCH_BIT     = 2;
    localparam int ABR_AP_CLAMP_RES_BIT = 1;
    localparam int ABR_AP_CLAMP_BIT     = 0;

    // mid-rail divider codes
    localparam logic [1:0] ABR_MID_OFF     = 2'h0;
    localparam logic [1:0] ABR_MID_NORMAL  = 2'h1;
    localparam logic [1:0] ABR_MID_STANDBY = 2'h2;
    localparam logic [1:0] ABR_MID_FAST    = 2'h3;

    // bias current in quarters of the normal bias
    localparam logic [2:0] ABR_BIAS_Q_QUARTER  = 3'h1;
    localparam logic [2:0] ABR_BIAS_Q_HALF     = 3'h2;
    localparam logic [2:0] ABR_BIAS_Q_3QUARTER = 3'h3;
    localparam logic [2:0] ABR_BIAS_Q_FULL     = 3'h4;
    localparam logic [2:0] ABR_BIAS_Q_1P5      = 3'h6;

    typedef logic [15:0] abr_word_t;

endpackage
`default_nettype wire

// [abr_field_reg.sv]
// Purpose: one masked control register with a fixed reset value
// Assumes: synchronous active-high reset on sys_clk
// Notes:   unmasked bits never store a one
`timescale 1ns/1ps
`default_nettype none
module abr_field_reg
    import abr_pkg::*;
#(
    parameter abr_word_t MASK  = 16'hffff,
    parameter abr_word_t RESET = 16'h0000
)
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        wr_en,
    input  wire abr_word_t   wdata,
    output var  abr_word_t   q
);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            q <= RESET & MASK;
        end
        else if (wr_en)
        begin
            q <= wdata & MASK;
        end
    end

endmodule
`default_nettype wire

// [abr_bias_regs_props.sv]
// Purpose: port checker for the bias control register bank
// Assumes: one clock, rst synchronous active high
// Notes:   fields land one cycle after a write, derived flags one more
`timescale 1ns/1ps
`default_nettype none
module abr_bias_regs_props
    import abr_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        reg_wr_en,
    input wire logic        reg_rd_en,
    input wire logic [6:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_addr_hit,
    input wire logic        line_output_enable,
    input wire logic [1:0]  midrail_divider_select,
    input wire logic        midrail_slew_fast,
    input wire logic        midrail_soft_start,
    input wire logic        midrail_buffer_enable,
    input wire logic        bias_source_select,
    input wire logic        standby_bias_level,
    input wire logic        standby_bias_enable,
    input wire logic [1:0]  master_bias_level,
    input wire logic        normal_bias_enable,
    input wire logic        startup_bias_enable,
    input wire logic [2:0]  bias_current_quarters,
    input wire logic        dac_path_enable,
    input wire logic        input_two_attenuate,
    input wire logic        input_two_enable,
    input wire logic        input_one_attenuate,
    input wire logic        input_one_enable,
    input wire logic        line_output_discharge,
    input wire logic        line_clamp_resistance,
    input wire logic        line_clamp_request,
    input wire logic        line_clamp_active,
    input wire logic        line_clamp_low_ohm,
    input wire logic        line_clamp_unbuffered
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff rst;

    midrail_wr_a: assert property (reg_wr_en && reg_addr == ABR_MIDRAIL_ADDR |=>
        {midrail_buffer_enable, midrail_soft_start, midrail_divider_select, midrail_slew_fast}
        == $past({reg_wdata[5], reg_wdata[3:0]})) else $error("midrail write mismatch");
    bias_wr_a: assert property (reg_wr_en && reg_addr == ABR_BIAS_ADDR |=>
        {bias_source_select, standby_bias_level, standby_bias_enable, master_bias_level,
        normal_bias_enable, startup_bias_enable} == $past(reg_wdata[6:0])) else $error("bias write mismatch");
    mixer_wr_a: assert property (reg_wr_en && reg_addr == ABR_MIXER_ADDR |=>
        {dac_path_enable, input_two_attenuate, input_two_enable, input_one_attenuate, input_one_enable}
        == $past(reg_wdata[4:0])) else $error("mixer write mismatch");
    antipop_wr_a: assert property (reg_wr_en && reg_addr == ABR_ANTIPOP_ADDR |=>
        {line_output_discharge, line_clamp_resistance, line_clamp_request} == $past(reg_wdata[2:0]))
        else $error("anti-pop write mismatch");
    clamp_gate_a: assert property (1'b1 |=>
        line_clamp_active == $past(line_clamp_request && !line_output_enable)) else $error("clamp gating wrong");
    low_ohm_a: assert property (!line_clamp_resistance |=> !line_clamp_low_ohm)
        else $error("low ohm clamp without resistance bit");
    unbuffered_flag_a: assert property (1'b1 |=> line_clamp_unbuffered ==
        $past(line_clamp_request && !line_output_enable && !midrail_buffer_enable))
        else $error("unbuffered clamp flag wrong");
    stby_level_a: assert property (standby_bias_enable |=>
        bias_current_quarters == ($past(standby_bias_level) ? ABR_BIAS_Q_QUARTER : ABR_BIAS_Q_HALF))
        else $error("standby bias level wrong");
    unmapped_wr_a: assert property (reg_wr_en && !reg_addr_hit |=>
        $stable({midrail_divider_select, master_bias_level, dac_path_enable, line_clamp_request}))
        else $error("unmapped write changed a field");
    reset_val_a: assert property ($fell(rst) |-> midrail_slew_fast && bias_source_select
        && standby_bias_level && master_bias_level == 2'h2 && !standby_bias_enable) else $error("bad reset value");
    midrail_rd_a: assert property (reg_rd_en && reg_addr == ABR_MIDRAIL_ADDR |=> reg_rdata ==
        $past({10'h000, midrail_buffer_enable, 1'b0, midrail_soft_start, midrail_divider_select,
        midrail_slew_fast})) else $error("midrail read mismatch");

    cover property (line_clamp_active && line_clamp_low_ohm);
    cover property (standby_bias_enable && standby_bias_level);
    cover property (reg_wr_en && !reg_addr_hit);
endmodule

bind abr_bias_regs abr_bias_regs_props chk (.*);
`default_nettype wire

// [test_abr_bias_regs.sv]
// Purpose: self-checking bench for the bias control register bank
// Assumes: inputs driven on the falling edge of sys_clk
// Notes:   reset values first, then table rows, decode, level and clamp cases, then a second reset
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) \
    begin \
        n_checks++; \
        if ((a) !== (b)) \
        begin \
            errors++; \
            $display("wrong value at %0t: %h %h", $time, a, b); \
        end \
    end
module test_abr_bias_regs import abr_pkg::*;;
    typedef struct {logic [6:0] a; logic [15:0] w; logic [15:0] r;} abr_row_t;
    logic sys_clk = 0, rst = 1, reg_wr_en = 0, reg_rd_en = 0, line_output_enable = 0;
    logic [6:0] reg_addr = 7'h00;
    logic [15:0] reg_wdata = 16'h0000;
    wire logic [15:0] reg_rdata;
    wire logic [3:0] midrail_divider_onehot;
    wire logic [2:0] bias_current_quarters;
    wire logic [1:0] midrail_divider_select, master_bias_level;
    wire logic reg_rd_valid, reg_addr_hit, midrail_slew_fast, midrail_soft_start, midrail_buffer_enable,
        bias_source_select, standby_bias_level, standby_bias_enable, normal_bias_enable, startup_bias_enable,
        selected_bias_running, dac_path_enable, input_one_enable, input_one_attenuate, input_two_enable,
        input_two_attenuate, line_output_discharge, line_clamp_request, line_clamp_resistance,
        line_clamp_active, line_clamp_low_ohm, line_clamp_unbuffered;
    int errors = 0, n_checks = 0;
    logic [2:0] lvl_q [4] = '{3'h2, 3'h3, 3'h4, 3'h6};
    abr_row_t rows [8] = '{'{7'h04, 16'hffff, 16'h002f}, '{7'h04, 16'h0004, 16'h0004},
        '{7'h05, 16'hffff, 16'h007f}, '{7'h05, 16'h0010, 16'h0010}, '{7'h07, 16'hffff, 16'h001f},
        '{7'h07, 16'h000a, 16'h000a}, '{7'h08, 16'hffff, 16'h0007}, '{7'h08, 16'h0005, 16'h0005}};

    abr_bias_regs dut (.*);

    always #4 sys_clk = ~sys_clk;

    task summarize;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task wr(input logic [6:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        reg_wr_en = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_wr_en = 0;
    endtask

    // one read, data and valid seen one cycle after the strobe
    task rd(input logic [6:0] a, input logic [15:0] e);
        @(negedge sys_clk);
        reg_rd_en = 1;
        reg_addr = a;
        @(negedge sys_clk);
        `CK(reg_rd_valid, 1'b1)
        `CK(reg_rdata, e)
        reg_rd_en = 0;
    endtask

    // write then let the derived outputs land
    task wrs(input logic [6:0] a, input logic [15:0] d);
        wr(a, d);
        @(negedge sys_clk);
    endtask

    initial
    begin
        repeat (2000) @(posedge sys_clk);
        errors++;
        summarize();
    end

    initial
    begin
        repeat (12) @(negedge sys_clk);
        rst = 0;
        rd(7'h04, 16'h0001);
        rd(7'h05, 16'h0068);
        rd(7'h07, 16'h0000);
        rd(7'h08, 16'h0000);
        `CK(midrail_divider_onehot, 4'h1)
        `CK(bias_current_quarters, ABR_BIAS_Q_FULL)
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].r);
        end
        wr(7'h06, 16'hffff);
        rd(7'h06, 16'h0000);
        `CK(reg_addr_hit, 1'b0)
        rd(7'h05, 16'h0010);
        `CK(reg_addr_hit, 1'b1)
        @(negedge sys_clk);
        `CK(reg_rd_valid, 1'b0)
        for (int i = 0; i < 4; i++)
        begin
            wrs(7'h04, 16'(i << 1));
            `CK(midrail_divider_onehot, 4'(1 << i))
            wrs(7'h05, 16'(i << 2));
            `CK(bias_current_quarters, lvl_q[i])
        end
        wrs(7'h05, 16'h0010);
        `CK(bias_current_quarters, ABR_BIAS_Q_HALF)
        wrs(7'h05, 16'h0030);
        `CK(bias_current_quarters, ABR_BIAS_Q_QUARTER)
        wrs(7'h05, 16'h0041);
        `CK(selected_bias_running, 1'b1)
        wrs(7'h05, 16'h0042);
        `CK(selected_bias_running, 1'b0)
        wrs(7'h08, 16'h0003);
        `CK({line_clamp_active, line_clamp_low_ohm, line_clamp_unbuffered}, 3'h7)
        wrs(7'h04, 16'h0020);
        `CK(line_clamp_unbuffered, 1'b0)
        line_output_enable = 1;
        repeat (2) @(negedge sys_clk);
        `CK({line_clamp_active, line_clamp_low_ohm}, 2'h0)
        wr(7'h08, 16'h0004);
        `CK({line_output_discharge, line_clamp_request}, 2'h2)
        rst = 1;
        repeat (2) @(negedge sys_clk);
        rst = 0;
        rd(7'h05, 16'h0068);
        rd(7'h08, 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire
